// ==== inc/qcr_cfg.svh ====
/*
  Register offsets, field positions, reset values and counts shared by both ends
  of the coder parameter/command link and by the host's APB register set.
  Assumes inclusion by bare name from the package and the link property checker.
*/
`ifndef QCR_CFG_SVH
`define QCR_CFG_SVH

// ----------------------------------------------------------------------------
// device register map (8-bit host bus)
// ----------------------------------------------------------------------------
`define QCR_ADDR_SYSTEM     4'h0
`define QCR_ADDR_PARAM      4'h1
`define QCR_ADDR_CMD_STAT   4'h2

`define QCR_SYS_RESET       8'h00
`define QCR_PARAM_RESET     8'h00
`define QCR_SYS_ORDER_BIT   3
`define QCR_SYS_KIND_BIT    6
`define QCR_SYS_WIDTH_BIT   7
`define QCR_SYS_MASK        8'hC8

`define QCR_PAR_AT_LO_MSB   4
`define QCR_PAR_TM_BIT      5
`define QCR_PAR_AT_HI_LSB   6
`define QCR_PAR_AT_HI_MSB   7

`define QCR_CMD_IC_BIT      0
`define QCR_CMD_JC_BIT      1
`define QCR_CMD_RC_BIT      2
`define QCR_CMD_JP_BIT      3

`define QCR_ST_JS_BIT       0
`define QCR_ST_IS_BIT       3
`define QCR_ST_PS_BIT       5

`define QCR_RAM_INIT_CYCLES 9'h100
`define QCR_LINES_RESET     16'h0000

// ----------------------------------------------------------------------------
// host APB register map
// ----------------------------------------------------------------------------
`define QCR_APB_IRQ_STAT    8'h0C
`define QCR_APB_IRQ_MASK    8'h10
`define QCR_APB_PIX_WORD    8'h14
`define QCR_APB_WIN_LIMIT   8'h0C
`define QCR_IRQ_DEV_BIT     0
`define QCR_IRQ_PIX_BIT     1

`endif

// ==== inc/qcr_pkg.sv ====
/*
  Types and the shared pixel lane mapping of the coder register link.
  Assumes qcr_cfg.svh on the include path.
*/
`include "qcr_cfg.svh"

package qcr_pkg;

  typedef logic [7:0]  qcr_byte_t;
  typedef logic [3:0]  qcr_addr_t;
  typedef logic [31:0] qcr_word_t;

  // --------------------------------------------------------------------------
  // pixel lane mapping; pixel i is bit i of a word, pixel 0 leftmost
  // --------------------------------------------------------------------------
  // every mapping reverses or keeps the low 16 or all 32 bits and clears the rest, so it is its own inverse on those bits
  // and serves both the driving and the receiving end
  function automatic qcr_word_t qcr_lane_map(input qcr_word_t pix,
                                             input logic      width16,
                                             input logic      lsb_first);
    qcr_word_t r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (width16) begin
        if (i < 16) begin
          r[lsb_first ? i : 15 - i] = pix[i];
        end
      end else begin
        r[lsb_first ? i : 31 - i] = pix[i];
      end
    end
    return r;
  endfunction : qcr_lane_map

endpackage : qcr_pkg

// ==== inc/qcr_link_if.sv ====
/*
  Link between the host end and the coder device end: 8-bit register bus,
  completion interrupt and the parallel image bus. Assumes one common clock.
*/
interface qcr_link_if;
  import qcr_pkg::*;

  qcr_addr_t hb_addr;
  qcr_byte_t hb_wdata;
  logic      hb_wr;
  logic      hb_rd;
  qcr_byte_t hb_rdata;
  logic      hb_irq;
  qcr_word_t image_par_bus;
  logic      image_strobe;

  modport dev_mp (
    input  hb_addr,
    input  hb_wdata,
    input  hb_wr,
    input  hb_rd,
    output hb_rdata,
    output hb_irq,
    output image_par_bus,
    output image_strobe
  );

  modport host_mp (
    output hb_addr,
    output hb_wdata,
    output hb_wr,
    output hb_rd,
    input  hb_rdata,
    input  hb_irq,
    input  image_par_bus,
    input  image_strobe
  );
endinterface : qcr_link_if

// ==== rtl/qcr_device.sv ====
/*
  Coder device end: system, parameter and command registers on the 8-bit
  host bus, status read-back, job sequencing (context RAM init, processing
  with pause or termination) and the parallel image bus formatter.
  Assumes a core on the same clock that presents pixel words and line-done
  pulses, and a host that keeps to the programming limits below.
*/

module qcr_device
  import qcr_pkg::*;
(
  input  wire logic          MCLK,
  input  wire logic          RSTN,
  qcr_link_if.dev_mp         link,
  input  wire qcr_pkg::qcr_word_t PIX_WORD,
  input  wire logic          PIX_VALID,
  input  wire logic          LINE_DONE,
  input  wire logic [15:0]   LINE_COUNT,
  output logic               TEMPLATE_TWO_LINE,
  output logic [6:0]         AT_POS,
  output logic               RAM_INIT_BUSY,
  output logic               PROCESSING,
  output logic               LS_SESSION
);
  import qcr_pkg::*;

  typedef enum logic [3:0] {
    QCR_IDLE   = 4'b0001,
    QCR_INIT   = 4'b0010,
    QCR_RUN    = 4'b0100,
    QCR_PAUSED = 4'b1000
  } qcr_dev_state_t;

  qcr_dev_state_t state_q;
  qcr_byte_t      sys_q;
  qcr_byte_t      param_q;
  qcr_byte_t      rdata_q;
  logic           pause_sel_q;
  logic           ls_q;
  logic           done_q;
  logic           irq_q;
  logic [8:0]     init_cnt_q;
  logic [15:0]    lines_left_q;
  qcr_word_t      bus_q;
  logic           strobe_q;

  logic cmd_wr;
  logic stat_rd;
  logic start_cmd;
  logic stop_cmd;
  logic init_cmd;
  logic last_line;
  logic init_end;
  logic job_end;
  logic pause_end;

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  assign cmd_wr    = link.hb_wr && (link.hb_addr == `QCR_ADDR_CMD_STAT);
  assign stat_rd   = link.hb_rd && (link.hb_addr == `QCR_ADDR_CMD_STAT);
  assign init_cmd  = cmd_wr && link.hb_wdata[`QCR_CMD_IC_BIT];
  assign start_cmd = cmd_wr && link.hb_wdata[`QCR_CMD_JC_BIT];
  // clearing the start bit mid-run flushes the job as a termination
  assign stop_cmd  = cmd_wr && !link.hb_wdata[`QCR_CMD_JC_BIT] && (state_q == QCR_RUN);
  assign last_line = (state_q == QCR_RUN) && LINE_DONE && (lines_left_q <= 16'h0001);
  assign init_end  = (state_q == QCR_INIT) && (init_cnt_q == 9'h001);
  assign job_end   = (last_line && !pause_sel_q) || stop_cmd;
  assign pause_end = last_line && pause_sel_q && !stop_cmd;

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sys_q   <= `QCR_SYS_RESET;
      param_q <= `QCR_PARAM_RESET;
    end else if (link.hb_wr) begin
      if (link.hb_addr == `QCR_ADDR_SYSTEM) begin
        sys_q <= link.hb_wdata & `QCR_SYS_MASK;
      end
      if (link.hb_addr == `QCR_ADDR_PARAM) begin
        // position zero and the illegal small positions are passed as written
        param_q <= link.hb_wdata;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pause_sel_q <= 1'b0;
      ls_q        <= 1'b0;
    end else if (cmd_wr) begin
      pause_sel_q <= link.hb_wdata[`QCR_CMD_JP_BIT];
      ls_q        <= link.hb_wdata[`QCR_CMD_RC_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // job sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= QCR_IDLE;
    end else begin
      case (state_q)
        QCR_IDLE: begin
          if (init_cmd) begin
            state_q <= QCR_INIT;
          end else if (start_cmd) begin
            state_q <= QCR_RUN;
          end
        end
        QCR_INIT: begin
          if (init_end) begin
            state_q <= QCR_IDLE;
          end
        end
        QCR_RUN: begin
          if (job_end) begin
            state_q <= QCR_IDLE;
          end else if (pause_end) begin
            state_q <= QCR_PAUSED;
          end
        end
        QCR_PAUSED: begin
          if (start_cmd) begin
            state_q <= QCR_RUN;
          end else if (init_cmd) begin
            state_q <= QCR_INIT;
          end
        end
        default: begin
          state_q <= QCR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      init_cnt_q <= 9'h000;
    end else if (init_cmd && (state_q != QCR_RUN) && (state_q != QCR_INIT)) begin
      init_cnt_q <= `QCR_RAM_INIT_CYCLES;
    end else if (state_q == QCR_INIT) begin
      init_cnt_q <= init_cnt_q - 9'h001;
    end
  end

  // the line target is relative: each start, fresh or resumed, loads it anew
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      lines_left_q <= `QCR_LINES_RESET;
    end else if (start_cmd && (state_q != QCR_RUN) && (state_q != QCR_INIT)) begin
      lines_left_q <= LINE_COUNT;
    end else if ((state_q == QCR_RUN) && LINE_DONE && (lines_left_q != 16'h0000)) begin
      lines_left_q <= lines_left_q - 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // done flag and completion interrupt
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      done_q <= 1'b0;
    end else if (init_end || job_end) begin
      done_q <= 1'b1;
    end else if ((init_cmd || start_cmd) && (state_q != QCR_RUN)) begin
      // a pause end never sets it, so it stays clear until the job ends
      done_q <= 1'b0;
    end
  end

  // set wins over the clear by a status read in the same cycle
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_q <= 1'b0;
    end else if (init_end || job_end || pause_end) begin
      irq_q <= 1'b1;
    end else if (stat_rd) begin
      irq_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // register read-back; unmapped addresses read zero
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 8'h00;
    end else if (link.hb_rd) begin
      case (link.hb_addr)
        `QCR_ADDR_SYSTEM: begin
          rdata_q <= sys_q;
        end
        `QCR_ADDR_PARAM: begin
          rdata_q <= param_q;
        end
        `QCR_ADDR_CMD_STAT: begin
          rdata_q                 <= 8'h00;
          rdata_q[`QCR_ST_JS_BIT] <= done_q;
          rdata_q[`QCR_ST_IS_BIT] <= irq_q;
          rdata_q[`QCR_ST_PS_BIT] <= pause_sel_q;
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // image bus formatter
  // --------------------------------------------------------------------------
  // serial mode falls back to the plain 32-bit left-first layout
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      bus_q    <= 32'h0000_0000;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= PIX_VALID && (state_q == QCR_RUN);
      if (PIX_VALID && (state_q == QCR_RUN)) begin
        if (sys_q[`QCR_SYS_KIND_BIT]) begin
          bus_q <= qcr_lane_map(PIX_WORD, sys_q[`QCR_SYS_WIDTH_BIT],
                                sys_q[`QCR_SYS_ORDER_BIT]);
        end else begin
          bus_q <= qcr_lane_map(PIX_WORD, 1'b0, 1'b0);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign link.hb_rdata      = rdata_q;
  assign link.hb_irq        = irq_q;
  assign link.image_par_bus = bus_q;
  assign link.image_strobe  = strobe_q;

  assign TEMPLATE_TWO_LINE  = param_q[`QCR_PAR_TM_BIT];
  assign AT_POS             = {param_q[`QCR_PAR_AT_HI_MSB:`QCR_PAR_AT_HI_LSB],
                               param_q[`QCR_PAR_AT_LO_MSB:0]};
  assign RAM_INIT_BUSY      = state_q[1];
  assign PROCESSING         = state_q[2];
  assign LS_SESSION         = ls_q;

endmodule : qcr_device

// ==== rtl/qcr_host.sv ====
/*
  Host end: an APB slave whose words 0x00..0x08 pass straight through to the
  device registers 0..2 over the 8-bit bus, plus interrupt status, mask and the
  last received pixel word. Assumes the device answers reads one cycle later.
*/
module qcr_host
  import qcr_pkg::*;
(
  input  wire logic          MCLK,
  input  wire logic          RSTN,
  qcr_link_if.host_mp        link,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  output logic               IRQ
);
  import qcr_pkg::*;

  typedef enum logic [3:0] {
    QCH_IDLE = 4'b0001,
    QCH_BUS  = 4'b0010,
    QCH_WAIT = 4'b0100,
    QCH_DONE = 4'b1000
  } qcr_host_state_t;

  qcr_host_state_t state_q;
  qcr_addr_t       addr_q;
  qcr_byte_t       wdata_q;
  logic            wr_q;
  logic            rd_q;
  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;
  qcr_byte_t       sys_shadow_q;
  logic [1:0]      istat_q;
  logic [1:0]      imask_q;
  logic            irq_prev_q;
  logic            irq_out_q;
  qcr_word_t       pix_q;

  logic req;
  logic win;
  logic local_wr;
  logic [1:0] ev;

  assign req      = PSEL && PENABLE && (state_q == QCH_IDLE);
  assign win      = (PADDR < `QCR_APB_WIN_LIMIT) && (PADDR[1:0] == 2'b00);
  assign local_wr = req && PWRITE && !win;
  assign ev       = {link.image_strobe, link.hb_irq && !irq_prev_q};

  // --------------------------------------------------------------------------
  // APB sequencer and device bus cycles
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q   <= QCH_IDLE;
      addr_q    <= 4'h0;
      wdata_q   <= 8'h00;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      case (state_q)
        QCH_IDLE: begin
          if (req && win) begin
            addr_q  <= {2'b00, PADDR[3:2]};
            wdata_q <= PWDATA[7:0];
            wr_q    <= PWRITE;
            rd_q    <= !PWRITE;
            state_q <= QCH_BUS;
          end else if (req) begin
            pready_q  <= 1'b1;
            pslverr_q <= 1'b0;
            state_q   <= QCH_DONE;
            case (PADDR)
              `QCR_APB_IRQ_STAT: prdata_q <= {30'h0000_0000, istat_q};
              `QCR_APB_IRQ_MASK: prdata_q <= {30'h0000_0000, imask_q};
              `QCR_APB_PIX_WORD: prdata_q <= pix_q;
              default: begin
                prdata_q  <= 32'h0000_0000;
                pslverr_q <= 1'b1;
              end
            endcase
          end
        end
        QCH_BUS: begin
          wr_q    <= 1'b0;
          rd_q    <= 1'b0;
          state_q <= QCH_WAIT;
        end
        QCH_WAIT: begin
          // writes complete here too, read data has just arrived
          prdata_q  <= {24'h00_0000, link.hb_rdata};
          pready_q  <= 1'b1;
          pslverr_q <= 1'b0;
          state_q   <= QCH_DONE;
        end
        QCH_DONE: begin
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
          state_q   <= QCH_IDLE;
        end
        default: begin
          state_q <= QCH_IDLE;
        end
      endcase
    end
  end

  // the host keeps its own copy of the image format to undo the lane order
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sys_shadow_q <= `QCR_SYS_RESET;
    end else if (wr_q && (addr_q == `QCR_ADDR_SYSTEM)) begin
      sys_shadow_q <= wdata_q & `QCR_SYS_MASK;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pix_q <= 32'h0000_0000;
    end else if (link.image_strobe) begin
      if (sys_shadow_q[`QCR_SYS_KIND_BIT]) begin
        pix_q <= qcr_lane_map(link.image_par_bus, sys_shadow_q[`QCR_SYS_WIDTH_BIT],
                              sys_shadow_q[`QCR_SYS_ORDER_BIT]);
      end else begin
        pix_q <= qcr_lane_map(link.image_par_bus, 1'b0, 1'b0);
      end
    end
  end

  // --------------------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      istat_q    <= 2'b00;
      imask_q    <= 2'b00;
      irq_prev_q <= 1'b0;
      irq_out_q  <= 1'b0;
    end else begin
      irq_prev_q <= link.hb_irq;
      if (local_wr && (PADDR == `QCR_APB_IRQ_STAT)) begin
        istat_q <= (istat_q & ~PWDATA[1:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
      if (local_wr && (PADDR == `QCR_APB_IRQ_MASK)) begin
        imask_q <= PWDATA[1:0];
      end
      irq_out_q <= |(istat_q & imask_q);
    end
  end

  assign link.hb_addr  = addr_q;
  assign link.hb_wdata = wdata_q;
  assign link.hb_wr    = wr_q;
  assign link.hb_rd    = rd_q;
  assign PRDATA        = prdata_q;
  assign PREADY        = pready_q;
  assign PSLVERR       = pslverr_q;
  assign IRQ           = irq_out_q;

endmodule : qcr_host

// ==== verification/qcr_link_properties.sv ====
/*
  Concurrent checks on the link between the host end and the coder device end.
  Assumes instantiation beside the link interface, one clock, reset active low.
*/
`include "qcr_cfg.svh"

module qcr_link_properties (
  input wire logic               MCLK,
  input wire logic               RSTN,
  input wire qcr_pkg::qcr_addr_t hb_addr,
  input wire qcr_pkg::qcr_byte_t hb_wdata,
  input wire logic               hb_wr,
  input wire logic               hb_rd,
  input wire qcr_pkg::qcr_byte_t hb_rdata,
  input wire logic               hb_irq,
  input wire qcr_pkg::qcr_word_t image_par_bus,
  input wire logic               image_strobe
);
  import qcr_pkg::*;

  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // --------------------------------------------------------------------------
  // shadow of what the host last wrote
  // --------------------------------------------------------------------------
  logic      jp_q;
  qcr_byte_t par_q;
  qcr_byte_t sys_q;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      jp_q  <= 1'b0;
      par_q <= 8'h00;
      sys_q <= 8'h00;
    end else if (hb_wr) begin
      if (hb_addr == `QCR_ADDR_SYSTEM) sys_q <= hb_wdata & `QCR_SYS_MASK;
      if (hb_addr == `QCR_ADDR_PARAM) par_q <= hb_wdata;
      if (hb_addr == `QCR_ADDR_CMD_STAT) jp_q <= hb_wdata[`QCR_CMD_JP_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  AST_WR_ONE_CYCLE: assert property (hb_wr |=> !hb_wr)
    else $error("write pulse longer than one cycle");
  AST_RD_WR_APART: assert property (!(hb_wr && hb_rd))
    else $error("read and write together");
  AST_STROBE_ONE_CYCLE: assert property (image_strobe |=> !image_strobe)
    else $error("image strobe longer than one cycle");
  AST_BUS_WITH_STROBE: assert property ($changed(image_par_bus) |-> image_strobe)
    else $error("image bus moved without strobe");
  AST_RDATA_HOLDS: assert property (!hb_rd |=> $stable(hb_rdata))
    else $error("read byte moved without a read");
  AST_UNMAPPED_ZERO: assert property (hb_rd && hb_addr > 4'h2 |=> hb_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_PARAM_BACK: assert property (hb_rd && hb_addr == 4'h1 |=> hb_rdata == par_q)
    else $error("parameter read back wrong");
  AST_SYS_BACK: assert property (hb_rd && hb_addr == 4'h0 |=> hb_rdata == sys_q)
    else $error("system read back wrong");
  AST_STAT_LAYOUT: assert property (hb_rd && hb_addr == 4'h2 |=>
    (hb_rdata & 8'hD6) == 8'h00 && hb_rdata[5] == jp_q)
    else $error("status layout or pause mirror wrong");
  // init runs a fixed 256 cycles, small slack for the flag and irq flops
  AST_INIT_DONE_IRQ: assert property (
    hb_wr && hb_addr == 4'h2 && hb_wdata == 8'h01 && !hb_irq |-> ##[250:270] hb_irq)
    else $error("init completion interrupt missing");

endmodule : qcr_link_properties

// ==== verification/coder_param_and_command_regs_tb_top.sv ====
/*
  Self-checking bench: host end and device end joined by the link interface,
  APB master on the host side, core stub signals on the device side.
  Assumes the qcr package and link interface are compiled first.
*/
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

module coder_param_and_command_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import qcr_pkg::*;

  logic        MCLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, PIX_WORD, rd;
  logic        PIX_VALID, LINE_DONE, TEMPLATE_TWO_LINE, RAM_INIT_BUSY, PROCESSING;
  logic        LS_SESSION, er;
  logic [6:0]  AT_POS;
  logic [15:0] LINE_COUNT;
  int          err_total, comparisons;

  qcr_link_if link ();
  qcr_device u_qcr_device (.MCLK(MCLK), .RSTN(RSTN), .link(link), .PIX_WORD(PIX_WORD),
    .PIX_VALID(PIX_VALID), .LINE_DONE(LINE_DONE), .LINE_COUNT(LINE_COUNT),
    .TEMPLATE_TWO_LINE(TEMPLATE_TWO_LINE), .AT_POS(AT_POS), .RAM_INIT_BUSY(RAM_INIT_BUSY),
    .PROCESSING(PROCESSING), .LS_SESSION(LS_SESSION));
  qcr_host u_qcr_host (.MCLK(MCLK), .RSTN(RSTN), .link(link), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ));
  qcr_link_properties u_qcr_link_properties (.MCLK(MCLK), .RSTN(RSTN),
    .hb_addr(link.hb_addr), .hb_wdata(link.hb_wdata), .hb_wr(link.hb_wr), .hb_rd(link.hb_rd),
    .hb_rdata(link.hb_rdata), .hb_irq(link.hb_irq), .image_par_bus(link.image_par_bus),
    .image_strobe(link.image_strobe));

  // --------------------------------------------------------------------------
  // bus and stimulus helpers
  // --------------------------------------------------------------------------
  // values read right after an edge are the ones sampled at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // no wait limit here: only the watchdog ends a hung transfer
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge MCLK);
  endtask : wr

  task automatic line_done;
    @(posedge MCLK);
    LINE_DONE <= 1'b1;
    @(posedge MCLK);
    LINE_DONE <= 1'b0;
  endtask : line_done

  task automatic wait_irq;
    repeat (400) begin
      @(posedge MCLK);
      if (IRQ === 1'b1) break;
    end
  endtask : wait_irq

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] v [3] = '{8'h04, 8'h70, 8'hFF};
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd[7:0], 8'h00)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(er, 1'b1)
    foreach (v[i]) begin
      wr(8'h04, {24'h0, v[i]});
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd[7:0], v[i])
      `CHK(TEMPLATE_TWO_LINE, v[i][5])
      `CHK(AT_POS, {v[i][7:6], v[i][4:0]})
    end
    wr(8'h04, 32'h0);
    `CHK(AT_POS, 7'h00)
  endtask : t_regs

  task automatic t_init;
    wr(8'h10, 32'h2);
    wr(8'h0C, 32'h3);
    wr(8'h08, 32'h1);
    `CHK(RAM_INIT_BUSY, 1'b1)
    repeat (300) @(posedge MCLK);
    `CHK(RAM_INIT_BUSY, 1'b0)
    `CHK(IRQ, 1'b0)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(rd[0], 1'b1)
    wr(8'h10, 32'h3);
    `CHK(IRQ, 1'b1)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd[7:0] & 8'h21, 8'h01)
    wr(8'h0C, 32'h1);
    `CHK(IRQ, 1'b0)
  endtask : t_init

  task automatic t_pause;
    LINE_COUNT <= 16'd2;
    wr(8'h08, 32'h0A);
    `CHK(PROCESSING, 1'b1)
    line_done();
    repeat (3) @(posedge MCLK);
    `CHK(PROCESSING, 1'b1)
    line_done();
    wait_irq();
    `CHK(IRQ, 1'b1)
    `CHK(PROCESSING, 1'b0)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd[7:0] & 8'h21, 8'h20)
    wr(8'h0C, 32'h1);
    LINE_COUNT <= 16'd1;
    wr(8'h08, 32'h02);
    `CHK(PROCESSING, 1'b1)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd[5], 1'b0)
    line_done();
    wait_irq();
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd[7:0] & 8'h21, 8'h01)
    wr(8'h0C, 32'h3);
  endtask : t_pause

  task automatic t_pix;
    logic [7:0]  m [5] = '{8'h40, 8'h48, 8'hC0, 8'hC8, 8'h88};
    logic [31:0] p, e;
    p = 32'h1234_ABCD;
    LINE_COUNT <= 16'd100;
    foreach (m[k]) begin
      wr(8'h00, {24'h0, m[k]});
      wr(8'h08, 32'h02);
      PIX_WORD  <= p;
      PIX_VALID <= 1'b1;
      @(posedge MCLK);
      PIX_VALID <= 1'b0;
      @(posedge MCLK);
      e = 32'h0;
      // serial mode ignores width and swap: plain 32-bit layout
      for (int i = 0; i < 32; i++) begin
        if (!m[k][6] || !m[k][7]) e[(m[k][3] && m[k][6]) ? i : 31 - i] = p[i];
        else if (i < 16) e[m[k][3] ? i : 15 - i] = p[i];
      end
      `CHK(link.image_strobe, 1'b1)
      `CHK(link.image_par_bus, e)
      apb(1'b0, 8'h14, 32'h0);
      `CHK(rd, (m[k][6] && m[k][7]) ? {16'h0000, p[15:0]} : p)
      wr(8'h08, 32'h0);
      p = {p[30:0], ~p[31]};
    end
    PIX_VALID <= 1'b1;
    @(posedge MCLK);
    PIX_VALID <= 1'b0;
    @(posedge MCLK);
    `CHK(link.image_strobe, 1'b0)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(rd[1], 1'b1)
  endtask : t_pix

  task automatic t_session;
    wr(8'h08, 32'h04);
    `CHK(LS_SESSION, 1'b1)
    wr(8'h08, 32'h00);
    `CHK(LS_SESSION, 1'b0)
  endtask : t_session

  // --------------------------------------------------------------------------
  // run control
  // --------------------------------------------------------------------------
  task automatic final_report;
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    err_total++;
    final_report();
  end

  initial begin
    {RSTN, PSEL, PENABLE, PWRITE, PIX_VALID, LINE_DONE} = 6'h00;
    PADDR      = 8'h00;
    PWDATA     = 32'h0;
    PIX_WORD   = 32'h0;
    LINE_COUNT = 16'h0;
    repeat (16) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    t_regs();
    t_init();
    t_pause();
    t_pix();
    t_session();
    final_report();
  end

endmodule : coder_param_and_command_regs_tb_top
